// >>> logic/spi_fmt_pkg.sv
package spi_fmt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Frame geometry
    localparam int unsigned BYTE_BITS = 8;
    localparam int unsigned CNT_W     = 7;
    localparam int unsigned BITCNT_W  = 4;
    localparam logic [3:0]  LAST_BIT  = 4'h7;
    localparam logic [3:0]  FULL_BYTE = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // Clock rate field encoding and divide ratios in bus cycles per bit
    localparam logic [1:0] RATE_DIV_2   = 2'h0;
    localparam logic [1:0] RATE_DIV_8   = 2'h1;
    localparam logic [1:0] RATE_DIV_32  = 2'h2;
    localparam logic [1:0] RATE_DIV_128 = 2'h3;
    localparam logic [7:0] DIV_2        = 8'h02;
    localparam logic [7:0] DIV_8        = 8'h08;
    localparam logic [7:0] DIV_32       = 8'h20;
    localparam logic [7:0] DIV_128      = 8'h80;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] TX_RESET  = 8'h00;
    localparam logic [7:0] RX_RESET  = 8'h00;
    localparam logic       SSN_RESET = 1'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Control bits of the port, held by software outside this block
    typedef struct packed {
        logic       port_enable_bit;
        logic       master_select_bit;
        logic       clock_polarity_bit;
        logic       clock_phase_bit;
        logic [1:0] clock_rate_field;
        logic       fault_detect_enable;
    } cfg_t;

    // Transfer engine states
    typedef enum logic {
        ST_IDLE,
        ST_SHIFT
    } state_t;

endpackage

// >>> logic/spi_rate_divider.sv
module spi_rate_divider #(
    parameter int unsigned CNT_W = spi_fmt_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    // Control
    input  wire logic       run_en_i,
    input  wire logic [1:0] rate_i,
    // Ticks
    output logic            half_tick_o,
    output logic            bit_tick_o
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [7:0]       div_w;
    logic [CNT_W-1:0] last_w;
    logic [CNT_W-1:0] mid_w;

    // Divide ratio and the two tick points inside one bit time
    assign div_w  = (rate_i == spi_fmt_pkg::RATE_DIV_2)  ? spi_fmt_pkg::DIV_2  :
                    (rate_i == spi_fmt_pkg::RATE_DIV_8)  ? spi_fmt_pkg::DIV_8  :
                    (rate_i == spi_fmt_pkg::RATE_DIV_32) ? spi_fmt_pkg::DIV_32 :
                                                           spi_fmt_pkg::DIV_128;
    assign last_w = CNT_W'(div_w - 8'h01);
    assign mid_w  = CNT_W'((div_w >> 1) - 8'h01);

    // Wrap on >= so a rate change mid-count cannot run the counter away
    assign bit_tick_o  = run_en_i & (cnt_q >= last_w);
    assign half_tick_o = bit_tick_o | (run_en_i & (cnt_q == mid_w));
    assign cnt_d       = (!run_en_i || bit_tick_o) ? '0 : cnt_q + 1'b1;

    // Free-running count, held at zero while gated off to save power
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

// >>> logic/spi_byte_shifter.sv
module spi_byte_shifter #(
    parameter int unsigned W = spi_fmt_pkg::BYTE_BITS
) (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         rstn_i,
    // Shift controls
    input  wire logic         load_i,
    input  wire logic [W-1:0] load_data_i,
    input  wire logic         launch_i,
    input  wire logic         capture_i,
    input  wire logic         in_bit_i,
    // Data out
    output logic              tx_msb_o,
    output logic [W-1:0]      rx_word_o,
    output logic [W-1:0]      capture_word_o
);

    logic [W-1:0] tx_q;
    logic [W-1:0] rx_q;

    // Outgoing bit is always the top of the transmit half
    assign tx_msb_o       = tx_q[W-1];
    assign rx_word_o      = rx_q;
    assign capture_word_o = {rx_q[W-2:0], in_bit_i};

    // Transmit half: load wins, otherwise shift left on a launch edge
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_q <= spi_fmt_pkg::TX_RESET;
        end else if (load_i) begin
            tx_q <= load_data_i;
        end else if (launch_i) begin
            tx_q <= {tx_q[W-2:0], 1'b0};
        end
    end

    // Receive half: the sampled bit enters at the bottom
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_q <= spi_fmt_pkg::RX_RESET;
        end else if (capture_i) begin
            rx_q <= capture_word_o;
        end
    end

endmodule

// >>> logic/spi_transfer_format_engine.sv
module spi_transfer_format_engine #(
    parameter int unsigned W = spi_fmt_pkg::BYTE_BITS
) (
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              rstn_i,
    // Configuration
    input  wire spi_fmt_pkg::cfg_t cfg_i,
    input  wire logic              fault_clear_i,
    // Data strobes
    input  wire logic              wr_i,
    input  wire logic [W-1:0]      wr_data_i,
    output logic                   tx_empty_o,
    output logic                   rx_valid_o,
    output logic [W-1:0]           rx_data_o,
    output logic                   busy_o,
    output logic                   select_fault_flag_o,
    // Serial clock pin
    input  wire logic              serial_clock_pin_i,
    output logic                   serial_clock_pin_o,
    output logic                   serial_clock_pin_oe_o,
    // Master out, slave in pin
    input  wire logic              mosi_i,
    output logic                   mosi_o,
    output logic                   mosi_oe_o,
    // Master in, slave out pin
    input  wire logic              miso_i,
    output logic                   miso_o,
    output logic                   miso_oe_o,
    // Slave select input
    input  wire logic              slave_select_n_i
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    spi_fmt_pkg::state_t               state_q;
    spi_fmt_pkg::state_t               state_d;
    logic [spi_fmt_pkg::BITCNT_W-1:0]  bit_cnt_q;
    logic [spi_fmt_pkg::BITCNT_W-1:0]  bit_cnt_d;
    logic [W-1:0]                      tx_hold_q;
    logic                              tx_full_q;
    logic                              tx_full_d;
    logic                              sck_q;
    logic                              sck_d;
    logic                              sck_prev_q;
    logic                              ssn_prev_q;
    logic                              fault_q;

    logic master_w;
    logic idle_lvl_w;
    logic clock_phase_bit_w;
    logic en_w;
    logic mst_en_w;
    logic slv_en_w;
    logic sel_w;
    logic run_w;
    logic half_tick_w;
    logic bit_tick_w;
    logic s_edge_w;
    logic s_lead_w;
    logic s_trail_w;
    logic ss_fall_w;
    logic m_lead_w;
    logic m_trail_w;
    logic lead_w;
    logic trail_w;
    logic m_start_w;
    logic s_start_w;
    logic start_w;
    logic launch_w;
    logic capture_w;
    logic end_w;
    logic abort_w;
    logic load_w;
    logic fault_set_w;
    logic in_bit_w;
    logic tx_msb_w;
    logic [W-1:0] rx_word_w;
    logic [W-1:0] cap_word_w;

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode

    // Both roles share phase and polarity
    assign master_w   = cfg_i.master_select_bit;
    assign idle_lvl_w = cfg_i.clock_polarity_bit;
    assign clock_phase_bit_w     = cfg_i.clock_phase_bit;
    // A master mode fault drops the port until the flag is cleared
    assign en_w       = cfg_i.port_enable_bit & ~(fault_q & master_w);
    assign mst_en_w   = en_w & master_w;
    assign slv_en_w   = en_w & ~master_w;
    assign sel_w      = slv_en_w & ~slave_select_n_i;
    assign run_w      = (state_q == spi_fmt_pkg::ST_SHIFT);
    assign in_bit_w   = master_w ? miso_i : mosi_i;

    ////////////////////////////////////////////////////////////////////////////
    // Rate divider, clocked only while enabled as master

    spi_rate_divider #(
        .CNT_W       (spi_fmt_pkg::CNT_W)
    ) u_rate (
        .clock_i     (clock_i),
        .rstn_i      (rstn_i),
        .run_en_i    (mst_en_w),
        .rate_i      (cfg_i.clock_rate_field),
        .half_tick_o (half_tick_w),
        .bit_tick_o  (bit_tick_w)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock edge classification

    // Slave edges: clocks are ignored while select is high
    assign s_edge_w  = sel_w & (serial_clock_pin_i != sck_prev_q);
    assign s_lead_w  = s_edge_w & (serial_clock_pin_i != idle_lvl_w);
    assign s_trail_w = s_edge_w & (serial_clock_pin_i == idle_lvl_w);
    assign ss_fall_w = slv_en_w & ssn_prev_q & ~slave_select_n_i;

    // Master edges: each half tick toggles the generated clock
    assign m_lead_w  = run_w & half_tick_w & (sck_q == idle_lvl_w);
    assign m_trail_w = run_w & half_tick_w & (sck_q != idle_lvl_w);

    assign lead_w    = master_w ? m_lead_w  : (run_w & s_lead_w);
    assign trail_w   = master_w ? m_trail_w : (run_w & s_trail_w);

    ////////////////////////////////////////////////////////////////////////////
    // Start, shift and end events

    // Master waits for the next bit boundary, whatever the phase
    assign m_start_w = mst_en_w & ~run_w & tx_full_q & bit_tick_w;
    // Phase 1 starts on the first edge, phase 0 on the select fall
    assign s_start_w = ~run_w & (clock_phase_bit_w ? s_lead_w : ss_fall_w);
    assign start_w   = master_w ? m_start_w : s_start_w;

    // Phase 0 captures on leading edges, phase 1 on trailing edges
    assign capture_w = clock_phase_bit_w ? trail_w : lead_w;
    assign launch_w  = clock_phase_bit_w ? (lead_w & (bit_cnt_q != '0))
                              : (trail_w & (bit_cnt_q != spi_fmt_pkg::FULL_BYTE));
    assign end_w     = clock_phase_bit_w ? (trail_w & (bit_cnt_q == spi_fmt_pkg::LAST_BIT))
                              : (trail_w & (bit_cnt_q == spi_fmt_pkg::FULL_BYTE));

    // A slave losing select, or any disable, drops the byte at once
    assign abort_w   = run_w & (master_w ? ~mst_en_w : ~sel_w);

    // Shift register takes new data only while no transfer runs
    assign load_w    = ~run_w & tx_full_q & (master_w ? m_start_w : 1'b1);

    ////////////////////////////////////////////////////////////////////////////
    // Select fault: master select driven low, or slave deselected mid-byte

    assign fault_set_w = cfg_i.fault_detect_enable & cfg_i.port_enable_bit &
                         (master_w ? ~slave_select_n_i
                                   : (run_w & slave_select_n_i));

    ////////////////////////////////////////////////////////////////////////////
    // Byte shifter

    spi_byte_shifter #(
        .W              (W)
    ) u_shift (
        .clock_i        (clock_i),
        .rstn_i         (rstn_i),
        .load_i         (load_w),
        .load_data_i    (tx_hold_q),
        .launch_i       (launch_w & ~abort_w),
        .capture_i      (capture_w & ~abort_w),
        .in_bit_i       (in_bit_w),
        .tx_msb_o       (tx_msb_w),
        .rx_word_o      (rx_word_w),
        .capture_word_o (cap_word_w)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state and bit count

    always_comb begin
        state_d   = state_q;
        bit_cnt_d = bit_cnt_q;
        if (abort_w) begin
            state_d   = spi_fmt_pkg::ST_IDLE;
            bit_cnt_d = '0;
        end else if (start_w) begin
            state_d   = spi_fmt_pkg::ST_SHIFT;
            bit_cnt_d = '0;
        end else if (end_w) begin
            state_d   = spi_fmt_pkg::ST_IDLE;
            bit_cnt_d = '0;
        end else if (capture_w) begin
            bit_cnt_d = bit_cnt_q + 1'b1;
        end
    end

    // Master clock: phase 1 opens with an active edge, phase 0 idles first
    always_comb begin
        sck_d = idle_lvl_w;
        if (m_start_w && clock_phase_bit_w) begin
            sck_d = ~idle_lvl_w;
        end else if (run_w && master_w && !abort_w && !end_w) begin
            sck_d = half_tick_w ? ~sck_q : sck_q;
        end
    end

    // A write in the load cycle refills the holding register
    assign tx_full_d = wr_i | (tx_full_q & ~load_w);

    ////////////////////////////////////////////////////////////////////////////
    // Engine registers

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q   <= spi_fmt_pkg::ST_IDLE;
            bit_cnt_q <= '0;
            sck_q     <= 1'b0;
        end else begin
            state_q   <= state_d;
            bit_cnt_q <= bit_cnt_d;
            sck_q     <= sck_d;
        end
    end

    // Input history for slave edge and select detection
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sck_prev_q <= 1'b0;
            ssn_prev_q <= spi_fmt_pkg::SSN_RESET;
        end else begin
            sck_prev_q <= serial_clock_pin_i;
            ssn_prev_q <= slave_select_n_i;
        end
    end

    // Transmit holding register
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_hold_q <= spi_fmt_pkg::TX_RESET;
            tx_full_q <= 1'b0;
        end else begin
            if (wr_i) begin
                tx_hold_q <= wr_data_i;
            end
            tx_full_q <= tx_full_d;
        end
    end

    // Fault flag: a new fault in the clear cycle keeps the flag set
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault_set_w | (fault_q & ~fault_clear_i);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status outputs

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_valid_o          <= 1'b0;
            rx_data_o           <= spi_fmt_pkg::RX_RESET;
            busy_o              <= 1'b0;
            tx_empty_o          <= 1'b1;
            select_fault_flag_o <= 1'b0;
        end else begin
            rx_valid_o          <= end_w & ~abort_w;
            if (end_w && !abort_w) begin
                rx_data_o <= clock_phase_bit_w ? cap_word_w : rx_word_w;
            end
            busy_o              <= (state_d == spi_fmt_pkg::ST_SHIFT);
            tx_empty_o          <= ~tx_full_d;
            select_fault_flag_o <= fault_set_w | (fault_q & ~fault_clear_i);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers: clock pin in step with sck_q, data pins one register behind the shifter

    // Clock and data out are driven only as an enabled master
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            serial_clock_pin_o    <= 1'b0;
            serial_clock_pin_oe_o <= 1'b0;
            mosi_o                <= 1'b0;
            mosi_oe_o             <= 1'b0;
        end else begin
            serial_clock_pin_o    <= sck_d;
            serial_clock_pin_oe_o <= mst_en_w;
            mosi_o                <= tx_msb_w;
            mosi_oe_o             <= mst_en_w;
        end
    end

    // Slave output only while selected; top bit is ready before any edge
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            miso_o    <= 1'b0;
            miso_oe_o <= 1'b0;
        end else begin
            miso_o    <= tx_msb_w;
            miso_oe_o <= sel_w;
        end
    end

endmodule

// >>> test/spi_fmt_props.sv
module spi_fmt_props (
    // Clock, reset and controls
    input wire logic              clock_i,
    input wire logic              rstn_i,
    input wire spi_fmt_pkg::cfg_t cfg_i,
    input wire logic              wr_i,
    input wire logic              slave_select_n_i,
    // Watched outputs
    input wire logic              busy_o,
    input wire logic              rx_valid_o,
    input wire logic              select_fault_flag_o,
    input wire logic              serial_clock_pin_o,
    input wire logic              serial_clock_pin_oe_o,
    input wire logic              mosi_oe_o,
    input wire logic              miso_oe_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    // Idle enabled master
    wire logic m_go = cfg_i.port_enable_bit & cfg_i.master_select_bit & slave_select_n_i
                      & !busy_o & !select_fault_flag_o;
    wire logic m_flt = cfg_i.port_enable_bit & cfg_i.master_select_bit
                       & cfg_i.fault_detect_enable & !slave_select_n_i;

    ////////////////////////////////////////
    a_miso_only_sel: assert property (miso_oe_o |-> $past(!slave_select_n_i))
        else $error("miso on unselected");
    a_clock_as_master: assert property (serial_clock_pin_oe_o |->
        $past(cfg_i.port_enable_bit && cfg_i.master_select_bit))
        else $error("clock driven as non-master");
    a_pins_as_master: assert property (mosi_oe_o |-> serial_clock_pin_oe_o && !miso_oe_o)
        else $error("pin directions clash");
    a_clock_idle_lvl: assert property (serial_clock_pin_oe_o && !busy_o && $past(!busy_o)
        && $stable(cfg_i) && !select_fault_flag_o
        |-> serial_clock_pin_o == cfg_i.clock_polarity_bit)
        else $error("bad clock idle");
    a_rx_one_pulse: assert property (rx_valid_o |=> !rx_valid_o)
        else $error("rx strobe too long");
    a_rx_after_xfer: assert property (rx_valid_o |-> $past(busy_o) || $past(busy_o, 2))
        else $error("rx strobe unprompted");
    a_start_div_two: assert property (m_go && wr_i
        && cfg_i.clock_rate_field == spi_fmt_pkg::RATE_DIV_2 |-> ##[1:4] busy_o)
        else $error("slow start at divide 2");
    a_start_div_max: assert property (m_go && wr_i
        && cfg_i.clock_rate_field == spi_fmt_pkg::RATE_DIV_128 |-> ##[1:130] busy_o)
        else $error("slow start at divide 128");
    a_master_fault: assert property (m_flt |-> ##[1:2] select_fault_flag_o)
        else $error("fault not flagged");
    a_fault_quiets: assert property (select_fault_flag_o [*2] |->
        !serial_clock_pin_oe_o && !mosi_oe_o)
        else $error("faulted master drives");

    // Main scenarios reached
    c_master_byte: cover property (rx_valid_o && mosi_oe_o);
    c_slave_byte: cover property (rx_valid_o && miso_oe_o);
    c_fault_seen: cover property ($rose(select_fault_flag_o));
endmodule

bind spi_transfer_format_engine spi_fmt_props i_props (
    .clock_i, .rstn_i, .cfg_i, .wr_i, .slave_select_n_i, .busy_o, .rx_valid_o,
    .select_fault_flag_o, .serial_clock_pin_o, .serial_clock_pin_oe_o, .mosi_oe_o,
    .miso_oe_o
);

// >>> test/spi_far_slave.sv
module spi_far_slave (
    // Clock and mode
    input  wire logic       clock_i,
    input  wire logic       sel_i,
    input  wire logic       pol_i,
    input  wire logic       pha_i,
    // Serial lines
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    // Byte side
    input  wire logic [7:0] tx_i,
    output logic [7:0]      rx_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] sh_q;
    logic       act_q  = 1'b0;
    logic       sel_q  = 1'b0;
    logic       junk_q = 1'b0;
    logic [3:0] n_q    = 4'h0;
    wire logic  act    = sck_i ^ pol_i;
    wire logic  lead   = sel_i & act & !act_q;
    wire logic  trail  = sel_i & !act & act_q;
    wire logic  shift  = (lead && pha_i && n_q != 4'h0) || (trail && !pha_i);

    // Shift shows at once; released line toggles
    assign miso_o = sel_i ? sh_q[shift ? 6 : 7] : junk_q;

    // Edge-driven shifter in the port's mode
    always @(posedge clock_i) begin
        act_q  <= act;
        sel_q  <= sel_i;
        junk_q <= !junk_q;
        if (trail)
            n_q <= n_q + 4'h1;
        if ((lead && !pha_i) || (trail && pha_i))
            rx_o <= {rx_o[6:0], mosi_i};
        if ((sel_i && !sel_q) || n_q == 4'h8) begin
            sh_q <= tx_i;
            n_q  <= 4'h0;
        end else if (shift) begin
            sh_q <= {sh_q[6:0], 1'b0};
        end
    end
endmodule

// >>> test/spi_transfer_format_engine_tb_top.sv
module spi_transfer_format_engine_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin num_errors++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end

    logic              clock_i     = 1'b0;
    logic              rstn_i      = 1'b0;
    spi_fmt_pkg::cfg_t cfg         = '0;
    logic              fault_clear = 1'b0;
    logic              wr          = 1'b0;
    logic [7:0]        wr_data     = 8'h00;
    logic              ss_n        = 1'b1;
    logic              tb_sck      = 1'b0;
    logic              tb_mosi     = 1'b0;
    logic              far_sel     = 1'b0;
    logic [7:0]        far_tx      = 8'h00;
    logic [7:0]        far_rx, rx_data;
    logic              far_miso, tx_empty, rx_valid, busy, fault;
    logic              sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    int                num_errors   = 0;
    int                total_checks = 0;
    int                rx_cnt       = 0;
    int                cycles       = 0;
    // Wire levels from whoever drives
    wire logic         sck_w  = sck_oe ? sck_o : tb_sck;
    wire logic         mosi_w = mosi_oe ? mosi_o : tb_mosi;
    wire logic         miso_w = miso_oe ? miso_o : far_miso;

    spi_transfer_format_engine i_dut (
        .clock_i(clock_i), .rstn_i(rstn_i), .cfg_i(cfg), .fault_clear_i(fault_clear),
        .wr_i(wr), .wr_data_i(wr_data), .tx_empty_o(tx_empty), .rx_valid_o(rx_valid),
        .rx_data_o(rx_data), .busy_o(busy), .select_fault_flag_o(fault),
        .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
        .serial_clock_pin_oe_o(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o),
        .mosi_oe_o(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe),
        .slave_select_n_i(ss_n)
    );
    spi_far_slave i_far (
        .clock_i(clock_i), .sel_i(far_sel), .pol_i(cfg.clock_polarity_bit),
        .pha_i(cfg.clock_phase_bit), .sck_i(sck_w), .mosi_i(mosi_w), .miso_o(far_miso),
        .tx_i(far_tx), .rx_o(far_rx)
    );

    // Bus clock and hang guard
    always #2 clock_i = !clock_i;
    always @(posedge clock_i) begin
        cycles++;
        if (rx_valid === 1'b1)
            rx_cnt++;
        if (cycles == 60000) begin
            num_errors++;
            complete_run();
        end
    end

    ////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Port off while modes move
    task automatic setup(input logic ms, pol, pha, input logic [1:0] rate, input logic fde);
        @(negedge clock_i);
        cfg.port_enable_bit = 1'b0;
        ss_n   = 1'b1;
        tb_sck = pol;
        @(negedge clock_i);
        cfg     = {1'b0, ms, pol, pha, rate, fde};
        far_sel = 1'b0;
        @(negedge clock_i);
        cfg.port_enable_bit = 1'b1;
        repeat (3) @(negedge clock_i);
    endtask

    task automatic put(input logic [7:0] b);
        wr      = 1'b1;
        wr_data = b;
        @(negedge clock_i);
        wr = 1'b0;
    endtask

    task automatic wait_rx();
        int k = 0;
        while (rx_valid !== 1'b1 && k < 3000) begin
            @(negedge clock_i);
            k++;
        end
        `CHK("rx_valid", 1'b1, rx_valid)
    endtask

    // Bench as master to a slave port
    task automatic sxfer(input logic pha, pol, input logic [7:0] mo, output logic [7:0] mi);
        for (int i = 7; i >= 0; i--) begin
            tb_mosi = mo[i];
            if (pha)
                tb_sck = ~pol;
            repeat (4) @(negedge clock_i);
            mi[i]  = miso_w;
            tb_sck = pha ? pol : ~pol;
            if (!pha || i > 0)
                repeat (4) @(negedge clock_i);
            if (!pha)
                tb_sck = pol;
        end
    endtask

    task automatic mxfer(input logic [7:0] mb, sb);
        int k = 0;
        far_tx  = sb;
        far_sel = 1'b1;
        put(mb);
        while (busy !== 1'b1 && k < 200) begin
            @(negedge clock_i);
            k++;
        end
        `CHK("start delay", 1'b1, k <= (2 << (2 * cfg.clock_rate_field)) + 2)
        wait_rx();
        `CHK("master rx", sb, rx_data)
        repeat (3) @(negedge clock_i);
        `CHK("far rx", mb, far_rx)
        `CHK("clock idle", cfg.clock_polarity_bit, sck_w)
        far_sel = 1'b0;
    endtask

    ////////////////////////////////////////
    task automatic master_modes();
        for (int m = 0; m < 16; m++) begin
            setup(1'b1, m[3], m[2], m[1:0], 1'b0);
            mxfer(8'hA5 ^ 8'(m), 8'h3C + 8'(m));
        end
    endtask

    // Mid-transfer write waits for the next byte
    task automatic master_queue();
        setup(1'b1, 1'b0, 1'b1, 2'h1, 1'b0);
        far_tx  = 8'h81;
        far_sel = 1'b1;
        put(8'h5B);
        repeat (12) @(negedge clock_i);
        far_tx = 8'h42;
        put(8'hD2);
        @(negedge clock_i);
        `CHK("held byte", 1'b0, tx_empty)
        wait_rx();
        `CHK("first rx", 8'h81, rx_data)
        repeat (2) @(negedge clock_i);
        `CHK("first out", 8'h5B, far_rx)
        @(negedge clock_i);
        wait_rx();
        `CHK("second rx", 8'h42, rx_data)
        repeat (3) @(negedge clock_i);
        `CHK("second out", 8'hD2, far_rx)
        far_sel = 1'b0;
    endtask

    task automatic slave_pha0();
        logic [7:0] mi;
        setup(1'b0, 1'b1, 1'b0, 2'h0, 1'b0);
        put(8'hC3);
        repeat (2) @(negedge clock_i);
        `CHK("idle miso oe", 1'b0, miso_oe)
        ss_n = 1'b0;
        repeat (2) @(negedge clock_i);
        `CHK("miso oe", 1'b1, miso_oe)
        `CHK("first bit", 1'b1, miso_o)
        sxfer(1'b0, 1'b1, 8'h5A, mi);
        wait_rx();
        `CHK("slave rx", 8'h5A, rx_data)
        `CHK("slave tx", 8'hC3, mi)
        ss_n = 1'b1;
        repeat (2) @(negedge clock_i);
        `CHK("released", 1'b0, miso_oe)
    endtask

    // Select low over two bytes, second written mid-byte
    task automatic slave_pha1();
        logic [7:0] mi;
        setup(1'b0, 1'b0, 1'b1, 2'h0, 1'b0);
        put(8'h96);
        ss_n = 1'b0;
        repeat (3) @(negedge clock_i);
        `CHK("no start yet", 1'b0, busy)
        fork
            sxfer(1'b1, 1'b0, 8'hE1, mi);
            begin
                repeat (20) @(negedge clock_i);
                put(8'h69);
            end
        join
        wait_rx();
        `CHK("slave rx 1", 8'hE1, rx_data)
        `CHK("slave tx 1", 8'h96, mi)
        repeat (4) @(negedge clock_i);
        sxfer(1'b1, 1'b0, 8'h1E, mi);
        wait_rx();
        `CHK("slave rx 2", 8'h1E, rx_data)
        `CHK("slave tx 2", 8'h69, mi)
        ss_n = 1'b1;
    endtask

    task automatic slave_unsel();
        int c;
        logic [7:0] mi;
        setup(1'b0, 1'b0, 1'b1, 2'h0, 1'b0);
        c = rx_cnt;
        sxfer(1'b1, 1'b0, 8'hFF, mi);
        repeat (4) @(negedge clock_i);
        `CHK("unselected rx", c, rx_cnt)
        `CHK("unselected oe", 1'b0, miso_oe)
        `CHK("unselected busy", 1'b0, busy)
    endtask

    // Gated master holds its byte; select low faults it
    task automatic master_gate();
        setup(1'b1, 1'b0, 1'b0, 2'h2, 1'b1);
        cfg.port_enable_bit = 1'b0;
        far_tx  = 8'h77;
        far_sel = 1'b1;
        put(8'h0F);
        repeat (100) @(negedge clock_i);
        `CHK("gated busy", 1'b0, busy)
        `CHK("gated clock oe", 1'b0, sck_oe)
        cfg.port_enable_bit = 1'b1;
        wait_rx();
        `CHK("late rx", 8'h77, rx_data)
        far_sel = 1'b0;
        ss_n    = 1'b0;
        repeat (3) @(negedge clock_i);
        `CHK("fault flag", 1'b1, fault)
        `CHK("fault oe", 1'b0, mosi_oe)
        ss_n        = 1'b1;
        fault_clear = 1'b1;
        @(negedge clock_i);
        fault_clear = 1'b0;
        @(negedge clock_i);
        `CHK("fault cleared", 1'b0, fault)
    endtask

    initial begin
        repeat (4) @(negedge clock_i);
        rstn_i = 1'b1;
        master_modes();
        master_queue();
        slave_pha0();
        slave_pha1();
        slave_unsel();
        master_gate();
        complete_run();
    end
endmodule
